/* File: src/proc_reset_image_sequencer.sv */
// Processor reset and boot-image sequencer of the secure manager
`timescale 1ns/1ps
// Notes on behaviour
// RL1: Cold-reset pin active starts a cold reset of processor and peripherals.
// RL2: Cold-reset pin is driven active whenever the processor is in reset.
// RL3: Reconfig request holds off or restarts fabric config and cold resets processor.
// RL4: External driver holds reconfig and cold-reset pins for minimum time.
// RL5: Board must not tie cold-reset pin to configuration flash reset.
// RL6: After power-on reset, production images are tried in configured order.
// RL7: If all production images fail, the factory image is loaded.
// RL8: Factory select pin at power-on reset skips production images entirely.
// RL9: Any of four watchdogs expiring triggers the configured one of three responses.
// RL10: Cold response reloads loader from previous image, then releases processor.
// RL11: Cold response leaves fabric configuration untouched.
// RL12: Warm response holds then releases processor without reloading.
// RL13: Warm response leaves fabric unchanged.
// RL14: Update response loads loader from next valid image or factory, then releases.
// RL15: Update response erases fabric then reconfigures from next valid or factory.
// RL16: Flash must always hold a valid factory core image.
// RL17: Failed loader load keeps processor in reset; response is static three-value setting.
module proc_reset_image_sequencer (
    input wire logic clk, // Manager clock, 25 MHz
    input wire logic rst, // Power-on reset, async, active high
    input wire logic cold_reset_in_n, // Cold-reset pin level seen at pad
    output logic cold_reset_out, // Cold-reset pin output value (low)
    output logic cold_reset_oe_n, // Cold-reset pin enable, low drives
    input wire logic reconfig_request_n, // Reconfiguration request pin, active low
    input wire logic factory_select_pin, // Direct-to-factory pin, active high
    input wire logic [reset_seq_pkg::NUM_WDOG-1:0] wdog_expired, // Watchdog expiry pulses
    input wire reset_seq_pkg::wd_resp_t wd_resp_cfg, // Static watchdog response
    input wire logic order_wr_en, // Boot order write strobe
    input wire logic [reset_seq_pkg::STEP_W-1:0] order_wr_addr, // Boot order step
    input wire logic [reset_seq_pkg::SLOT_W:0] order_wr_data, // Valid flag and slot
    output reset_seq_pkg::load_req_t load_req, // Image load request
    input wire reset_seq_pkg::load_resp_t load_resp, // Image load response
    output reset_seq_pkg::fabric_ctl_t fabric_ctl, // Fabric erase and busy
    output logic proc_reset, // Processor subsystem reset, active high
    output logic [reset_seq_pkg::SLOT_W-1:0] cur_slot, // Slot of last good image
    output logic cur_factory, // Last good image is factory
    output logic load_failed // Sequence ended in failure
);
    reset_seq_pkg::seq_state_t state_q, state_d;
    logic [reset_seq_pkg::STEP_W-1:0] step_q;
    logic try_factory_q;
    logic reload_core_q;
    logic same_image_q;
    logic [reset_seq_pkg::CNT_W-1:0] cnt_q;
    logic [reset_seq_pkg::SLOT_W:0] order_rd;
    logic pin_q;
    logic cfg_q;
    logic wd_any;
    logic cold_req;
    logic cfg_req;
    logic req_pend_q;
    logic [reset_seq_pkg::SLOT_W-1:0] good_slot_q;
    logic good_factory_q;
    logic load_busy_q;
    logic settle_q;
    logic slot_ok;
    logic run_evt;

    function automatic logic step_last(input logic [reset_seq_pkg::STEP_W-1:0] s);
        return s == reset_seq_pkg::STEP_W'(reset_seq_pkg::NUM_SLOTS - 1);
    endfunction

    function automatic logic [reset_seq_pkg::STEP_W-1:0] step_next(input logic [reset_seq_pkg::STEP_W-1:0] s);
        return s + 1'b1;
    endfunction

    boot_order_mem u_order (
        .clk(clk),
        .rst(rst),
        .wr_en(order_wr_en),
        .wr_addr(order_wr_addr),
        .wr_data(order_wr_data),
        .rd_addr(step_q),
        .rd_data(order_rd)
    );

    // Edge sources for the reset requests
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pin_q <= 1'b1;
            // Low so a request held through power-on is no edge
            cfg_q <= 1'b0;
        end else begin
            pin_q <= cold_reset_in_n;
            cfg_q <= reconfig_request_n;
        end
    end

    // RL9: any watchdog expiry
    assign wd_any = |wdog_expired;
    // RL1: external cold reset
    assign cold_req = !cold_reset_in_n && pin_q && (state_q == reset_seq_pkg::ST_RUN);
    // RL3: reconfig falling edge
    assign cfg_req = !reconfig_request_n && cfg_q;
    assign run_evt = (state_q == reset_seq_pkg::ST_RUN) && (cold_req || wd_any);
    assign slot_ok = try_factory_q || order_rd[reset_seq_pkg::SLOT_W];

    // Fabric needs reconfiguration after a reconfig request
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            req_pend_q <= 1'b0;
        end else if (cfg_req) begin
            req_pend_q <= 1'b1;
        end else if (state_q == reset_seq_pkg::ST_POR_SEL && reconfig_request_n) begin
            req_pend_q <= 1'b0;
        end
    end

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            reset_seq_pkg::ST_HOLD: begin
                // RL3: hold off configuration while request held
                if (reconfig_request_n) begin
                    state_d = reset_seq_pkg::ST_POR_SEL;
                end
            end
            reset_seq_pkg::ST_POR_SEL: begin
                state_d = reset_seq_pkg::ST_ERASE;
            end
            reset_seq_pkg::ST_ERASE: begin
                if (cnt_q == '0) begin
                    state_d = reset_seq_pkg::ST_CORE_LOAD;
                end
            end
            reset_seq_pkg::ST_CORE_LOAD: begin
                if (settle_q) begin
                    state_d = reset_seq_pkg::ST_CORE_LOAD;
                end else if (!slot_ok) begin
                    state_d = reset_seq_pkg::ST_NEXT;
                end else if (load_resp.done) begin
                    state_d = load_resp.ok ? reset_seq_pkg::ST_LOADER_LOAD : reset_seq_pkg::ST_NEXT;
                end
            end
            reset_seq_pkg::ST_LOADER_LOAD: begin
                if (load_resp.done) begin
                    state_d = load_resp.ok ? reset_seq_pkg::ST_RELEASE : reset_seq_pkg::ST_NEXT;
                end
            end
            reset_seq_pkg::ST_NEXT: begin
                // RL17: failure of factory or same image stays in reset
                if (try_factory_q || same_image_q) begin
                    state_d = reset_seq_pkg::ST_FAIL;
                end else begin
                    state_d = reload_core_q ? reset_seq_pkg::ST_CORE_LOAD : reset_seq_pkg::ST_LOADER_LOAD;
                end
            end
            reset_seq_pkg::ST_RELEASE: begin
                if (cnt_q == '0) begin
                    state_d = reset_seq_pkg::ST_RUN;
                end
            end
            reset_seq_pkg::ST_RUN: begin
                // RL13: warm keeps fabric
                if (run_evt) begin
                    state_d = reset_seq_pkg::ST_RELEASE;
                end
            end
            reset_seq_pkg::ST_FAIL: begin
                state_d = reset_seq_pkg::ST_FAIL;
            end
            default: begin
                state_d = reset_seq_pkg::ST_HOLD;
            end
        endcase
        if (run_evt) begin
            if (cold_req || wd_resp_cfg == reset_seq_pkg::WD_COLD) begin
                // RL10: reload loader from same image
                state_d = reset_seq_pkg::ST_LOADER_LOAD;
            end else if (wd_resp_cfg == reset_seq_pkg::WD_COLD_UPDATE) begin
                // RL15: erase before next image
                state_d = reset_seq_pkg::ST_ERASE;
            end
        end
        // RL3: reconfig request restarts everything
        if (cfg_req || !reconfig_request_n) begin
            state_d = reset_seq_pkg::ST_HOLD;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= reset_seq_pkg::ST_HOLD;
        end else begin
            state_q <= state_d;
        end
    end

    // Image selection state
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            step_q <= '0;
            try_factory_q <= 1'b0;
            reload_core_q <= 1'b1;
            same_image_q <= 1'b0;
        end else if (state_q == reset_seq_pkg::ST_POR_SEL) begin
            step_q <= '0;
            // RL8: factory pin sampled at power-on skips production
            try_factory_q <= factory_select_pin && !req_pend_q;
            reload_core_q <= 1'b1;
            same_image_q <= 1'b0;
        end else if (run_evt) begin
            if (cold_req || wd_resp_cfg == reset_seq_pkg::WD_COLD) begin
                // RL11: fabric kept, loader only from same image
                reload_core_q <= 1'b0;
                same_image_q <= 1'b1;
            end else if (wd_resp_cfg == reset_seq_pkg::WD_COLD_UPDATE) begin
                // RL14: advance to next valid image
                reload_core_q <= 1'b1;
                same_image_q <= 1'b0;
                if (good_factory_q || step_last(step_q)) begin
                    try_factory_q <= 1'b1;
                end else begin
                    step_q <= step_next(step_q);
                end
            end
        end else if (state_q == reset_seq_pkg::ST_NEXT && !try_factory_q && !same_image_q) begin
            // RL6: next production slot in order
            reload_core_q <= 1'b1;
            if (step_last(step_q)) begin
                // RL7: fall back to factory
                try_factory_q <= 1'b1;
            end else begin
                step_q <= step_next(step_q);
            end
        end
    end

    // Erase and release timers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (state_d != state_q) begin
            cnt_q <= reset_seq_pkg::CNT_W'(reset_seq_pkg::RELEASE_CYC);
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    // Record the image that last loaded successfully
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            good_slot_q <= '0;
            good_factory_q <= 1'b0;
        end else if (state_q == reset_seq_pkg::ST_LOADER_LOAD && load_resp.done && load_resp.ok) begin
            good_slot_q <= order_rd[reset_seq_pkg::SLOT_W-1:0];
            good_factory_q <= try_factory_q;
        end
    end

    // One request per load phase
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_busy_q <= 1'b0;
        end else if (state_d != state_q) begin
            load_busy_q <= 1'b0;
        end else if (load_req.valid) begin
            load_busy_q <= 1'b1;
        end
    end

    // Order memory read lags a step change by one cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            settle_q <= 1'b0;
        end else begin
            settle_q <= (state_q == reset_seq_pkg::ST_NEXT);
        end
    end

    always_comb begin
        load_req.valid = 1'b0;
        if (!load_busy_q && !settle_q) begin
            if (state_q == reset_seq_pkg::ST_LOADER_LOAD) begin
                load_req.valid = 1'b1;
            end else if (state_q == reset_seq_pkg::ST_CORE_LOAD) begin
                load_req.valid = slot_ok;
            end
        end
        load_req.factory = try_factory_q;
        load_req.slot = same_image_q ? good_slot_q : order_rd[reset_seq_pkg::SLOT_W-1:0];
        load_req.core = (state_q == reset_seq_pkg::ST_CORE_LOAD);
    end

    // RL15: fabric erased before core reload
    assign fabric_ctl.erase = (state_q == reset_seq_pkg::ST_ERASE);
    // RL11: fabric idle outside erase and core load
    assign fabric_ctl.busy = (state_q == reset_seq_pkg::ST_ERASE) || (state_q == reset_seq_pkg::ST_CORE_LOAD);

    // RL12: processor held in reset until run
    assign proc_reset = (state_q != reset_seq_pkg::ST_RUN);
    // RL2: drive pin low while processor in reset
    assign cold_reset_out = 1'b0;
    assign cold_reset_oe_n = !proc_reset;
    // Record of the image now running
    assign cur_slot = good_slot_q;
    assign cur_factory = good_factory_q;
    assign load_failed = (state_q == reset_seq_pkg::ST_FAIL);
endmodule

/* File: shared/reset_seq_pkg.sv */
// Package for the processor reset and boot-image sequencer
package reset_seq_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned NUM_WDOG = 4;
    localparam int unsigned NUM_SLOTS = 4;
    localparam int unsigned SLOT_W = 2;
    localparam int unsigned STEP_W = 3;
    // Release stretch after a successful load, in ns
    localparam int unsigned RELEASE_NS = 200;
    localparam int unsigned RELEASE_CYC = (RELEASE_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned CNT_W = 8;

    // Watchdog response encoding (static configuration)
    typedef enum logic [1:0] {
        WD_COLD = 2'h0,
        WD_WARM = 2'h1,
        WD_COLD_UPDATE = 2'h2
    } wd_resp_t;

    typedef enum logic [8:0] {
        ST_HOLD = 9'h001,
        ST_POR_SEL = 9'h002,
        ST_ERASE = 9'h004,
        ST_CORE_LOAD = 9'h008,
        ST_LOADER_LOAD = 9'h010,
        ST_NEXT = 9'h020,
        ST_RELEASE = 9'h040,
        ST_RUN = 9'h080,
        ST_FAIL = 9'h100
    } seq_state_t;

    // Image load request towards the flash loader engine
    typedef struct packed {
        logic valid;
        logic factory;
        logic [SLOT_W-1:0] slot;
        logic core;
    } load_req_t;

    typedef struct packed {
        logic done;
        logic ok;
    } load_resp_t;

    typedef struct packed {
        logic erase;
        logic busy;
    } fabric_ctl_t;
endpackage

/* File: src/boot_order_mem.sv */
// Small registered memory holding the user boot order of production slots
`timescale 1ns/1ps
module boot_order_mem (
    input wire logic clk, // Clock
    input wire logic rst, // Async reset, active high
    input wire logic wr_en, // Write strobe
    input wire logic [reset_seq_pkg::STEP_W-1:0] wr_addr, // Write step
    input wire logic [reset_seq_pkg::SLOT_W:0] wr_data, // Bit top valid, rest slot
    input wire logic [reset_seq_pkg::STEP_W-1:0] rd_addr, // Read step
    output logic [reset_seq_pkg::SLOT_W:0] rd_data // Registered read data
);
    localparam int unsigned DEPTH = 1 << reset_seq_pkg::STEP_W;
    logic [reset_seq_pkg::SLOT_W:0] mem_q [DEPTH];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
        end else if (wr_en) begin
            mem_q[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data <= '0;
        end else begin
            rd_data <= mem_q[rd_addr];
        end
    end
endmodule

/* File: sim/flash_loader_model.sv */
// Behavioural flash loader engine answering image load requests
`timescale 1ns/1ps
module flash_loader_model (
    input wire logic clk, // Clock
    input wire logic rst, // Async reset
    input wire reset_seq_pkg::load_req_t load_req, // Load request
    input wire logic [15:0] fail_mask, // Request codes that fail, except factory core loads
    input wire logic [3:0] delay, // Answer latency, at least 1
    output reset_seq_pkg::load_resp_t load_resp // Load answer
);
    logic [3:0] cnt_q;
    logic [3:0] code_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 4'h0;
            code_q <= 4'h0;
            load_resp <= '0;
        end else begin
            load_resp.done <= 1'b0;
            // Ok toggles while idle so it is never trusted without done
            load_resp.ok <= ~load_resp.ok;
            if (load_req.valid) begin
                cnt_q <= delay;
                code_q <= {load_req.factory, load_req.slot, load_req.core};
            end else if (cnt_q == 4'h1) begin
                cnt_q <= 4'h0;
                load_resp.done <= 1'b1;
                load_resp.ok <= (code_q[3] && code_q[0]) || !fail_mask[code_q];
            end else if (cnt_q != 4'h0) begin
                cnt_q <= cnt_q - 4'h1;
            end
        end
    end
endmodule

/* File: sim/proc_reset_image_sequencer_asserts.sv */
// Port-level checks for the reset and boot-image sequencer
`timescale 1ns/1ps
module proc_reset_image_sequencer_asserts (
    input wire logic clk, // Clock
    input wire logic rst, // Reset
    input wire logic cold_reset_in_n, // Pin level
    input wire logic cold_reset_out, // Pin value
    input wire logic cold_reset_oe_n, // Pin enable
    input wire logic reconfig_request_n, // Reconfig pin
    input wire logic [reset_seq_pkg::NUM_WDOG-1:0] wdog_expired, // Expiries
    input wire reset_seq_pkg::wd_resp_t wd_resp_cfg, // Response
    input wire reset_seq_pkg::load_req_t load_req, // Request
    input wire reset_seq_pkg::load_resp_t load_resp, // Answer
    input wire reset_seq_pkg::fabric_ctl_t fabric_ctl, // Fabric
    input wire logic proc_reset, // Processor reset
    input wire logic load_failed // Failure
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    wire wd_hit = !proc_reset && (|wdog_expired);
    sequence s_core_ok;
        (load_req.valid && load_req.core) ##[1:8] (load_resp.done && load_resp.ok);
    endsequence
    sequence s_ldr_ok;
        (load_req.valid && !load_req.core) ##[1:8] (load_resp.done && load_resp.ok);
    endsequence
    sequence s_ldr_bad;
        (load_req.valid && !load_req.core) ##[1:8] (load_resp.done && !load_resp.ok);
    endsequence
    property p_drive; cold_reset_oe_n == !proc_reset; endproperty
    a_drive: assert property (p_drive) else $error("pin enable mismatch");
    property p_low; !cold_reset_oe_n |-> !cold_reset_out; endproperty
    a_low: assert property (p_low) else $error("pin not driven low");
    property p_pin; !proc_reset && $fell(cold_reset_in_n) |-> ##[1:4] proc_reset; endproperty
    a_pin: assert property (p_pin) else $error("cold pin ignored");
    property p_rcfg; !proc_reset && !reconfig_request_n |-> ##[1:4] proc_reset; endproperty
    a_rcfg: assert property (p_rcfg) else $error("reconfig ignored");
    property p_wd; wd_hit |-> ##[1:4] proc_reset; endproperty
    a_wd: assert property (p_wd) else $error("watchdog ignored");
    property p_keep; wd_hit && wd_resp_cfg != reset_seq_pkg::WD_COLD_UPDATE |-> ##1 (!fabric_ctl.busy)[*8]; endproperty
    a_keep: assert property (p_keep) else $error("fabric touched");
    property p_warm; wd_hit && wd_resp_cfg == reset_seq_pkg::WD_WARM |-> ##1 (!load_req.valid)[*8]; endproperty
    a_warm: assert property (p_warm) else $error("warm reset loaded");
    property p_upd; wd_hit && wd_resp_cfg == reset_seq_pkg::WD_COLD_UPDATE |-> ##[1:4] fabric_ctl.erase; endproperty
    a_upd: assert property (p_upd) else $error("no erase on update");
    property p_order; s_core_ok |-> ##[1:3] (load_req.valid && !load_req.core); endproperty
    a_order: assert property (p_order) else $error("loader not after core");
    property p_rel; s_ldr_ok |-> ##[4:8] !proc_reset; endproperty
    a_rel: assert property (p_rel) else $error("no release after load");
    property p_hold; s_ldr_bad |-> ##1 proc_reset [*8]; endproperty
    a_hold: assert property (p_hold) else $error("released after bad load");
    property p_fail; load_failed |-> proc_reset; endproperty
    a_fail: assert property (p_fail) else $error("failed but released");
endmodule
bind proc_reset_image_sequencer proc_reset_image_sequencer_asserts i_proc_reset_image_sequencer_asserts (
    .clk(clk), .rst(rst), .cold_reset_in_n(cold_reset_in_n), .cold_reset_out(cold_reset_out),
    .cold_reset_oe_n(cold_reset_oe_n), .reconfig_request_n(reconfig_request_n), .wdog_expired(wdog_expired),
    .wd_resp_cfg(wd_resp_cfg), .load_req(load_req), .load_resp(load_resp), .fabric_ctl(fabric_ctl),
    .proc_reset(proc_reset), .load_failed(load_failed));

/* File: sim/proc_reset_image_sequencer_tb.sv */
// Self-checking bench for the reset and boot-image sequencer
`timescale 1ns/1ps
module proc_reset_image_sequencer_tb;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic ext_n = 1'b1;
    logic reconfig_request_n = 1'b0;
    logic factory_select_pin = 1'b0;
    logic [3:0] wdog_expired = 4'h0;
    reset_seq_pkg::wd_resp_t wd_resp_cfg = reset_seq_pkg::WD_COLD;
    logic order_wr_en = 1'b0;
    logic [2:0] order_wr_addr = 3'h0;
    logic [2:0] order_wr_data = 3'h0;
    logic [15:0] fail_mask = 16'h0000;
    logic [3:0] delay = 4'h1;
    logic pad_n, cold_reset_out, cold_reset_oe_n, proc_reset, cur_factory, load_failed;
    logic [1:0] cur_slot;
    reset_seq_pkg::load_req_t load_req;
    reset_seq_pkg::load_resp_t load_resp;
    reset_seq_pkg::fabric_ctl_t fabric_ctl;
    logic [3:0] reqs[$];
    logic [3:0] none[$];
    logic erase_seen = 1'b0;
    int err_count = 0;
    int n_checks = 0;
    always #20 clk = ~clk;
    // pad joined only to board pull-up and board reset source
    assign pad_n = ext_n & (cold_reset_oe_n | cold_reset_out);
    proc_reset_image_sequencer i_proc_reset_image_sequencer (.clk(clk), .rst(rst), .cold_reset_in_n(pad_n),
        .cold_reset_out(cold_reset_out), .cold_reset_oe_n(cold_reset_oe_n), .reconfig_request_n(reconfig_request_n),
        .factory_select_pin(factory_select_pin), .wdog_expired(wdog_expired), .wd_resp_cfg(wd_resp_cfg),
        .order_wr_en(order_wr_en), .order_wr_addr(order_wr_addr), .order_wr_data(order_wr_data), .load_req(load_req),
        .load_resp(load_resp), .fabric_ctl(fabric_ctl), .proc_reset(proc_reset), .cur_slot(cur_slot),
        .cur_factory(cur_factory), .load_failed(load_failed));
    flash_loader_model i_flash_loader_model (.clk(clk), .rst(rst), .load_req(load_req), .fail_mask(fail_mask),
        .delay(delay), .load_resp(load_resp));
    always @(posedge clk) begin
        if (load_req.valid === 1'b1) reqs.push_back({load_req.factory, load_req.slot, load_req.core});
        if (fabric_ctl.erase === 1'b1) erase_seen = 1'b1;
    end
    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("Error %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wait_for(input int sel, input int lim);
        for (int i = 0; i < lim; i++) begin
            if ((sel == 0 && proc_reset === 1'b0) || (sel == 1 && proc_reset === 1'b1)) return;
            if (sel == 2 && load_failed === 1'b1) return;
            @(posedge clk);
            #1;
        end
        err_count++;
        $display("Error %0t: wait %0d timed out", $time, sel);
        wrap_up();
    endtask
    task automatic chk_reqs(input logic [3:0] exp[$], input logic ers);
        chk(8'(reqs.size()), 8'(exp.size()), "request count");
        foreach (exp[k]) if (k < reqs.size()) chk({4'h0, reqs[k]}, {4'h0, exp[k]}, "request");
        chk({7'h0, erase_seen}, {7'h0, ers}, "erase");
        reqs.delete();
        erase_seen = 1'b0;
    endtask
    task automatic wr_order(input logic [2:0] step, input logic [2:0] data);
        @(posedge clk);
        order_wr_en <= 1'b1;
        order_wr_addr <= step;
        order_wr_data <= data;
        @(posedge clk);
        order_wr_en <= 1'b0;
    endtask
    task automatic power_up(input logic fac);
        @(posedge clk);
        rst <= 1'b1;
        reconfig_request_n <= 1'b0;
        factory_select_pin <= fac;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        wr_order(3'h0, 3'h6);
        wr_order(3'h1, 3'h0);
        wr_order(3'h2, 3'h4);
        wr_order(3'h3, 3'h0);
        reqs.delete();
        erase_seen = 1'b0;
        @(posedge clk);
        reconfig_request_n <= 1'b1;
    endtask
    task automatic fire_wd(input reset_seq_pkg::wd_resp_t cfg, input logic [3:0] hit);
        @(posedge clk);
        wd_resp_cfg <= cfg;
        @(posedge clk);
        wdog_expired <= hit;
        @(posedge clk);
        wdog_expired <= 4'h0;
        wait_for(1, 10);
    endtask
    task automatic t_boot();
        fail_mask <= 16'h0020;
        power_up(1'b0);
        wait_for(0, 300);
        chk_reqs('{4'h5, 4'h1, 4'h0}, 1'b1);
        chk({6'h0, cur_slot}, 8'h00, "slot");
        chk({7'h0, cold_reset_oe_n}, 8'h01, "pin release");
        $display("boot order test done");
    endtask
    task automatic t_wd_cold();
        delay <= 4'h6;
        fire_wd(reset_seq_pkg::WD_COLD, 4'h1);
        wait_for(0, 300);
        chk_reqs('{4'h0}, 1'b0);
        $display("cold response test done");
    endtask
    task automatic t_wd_warm();
        fire_wd(reset_seq_pkg::WD_WARM, 4'h2);
        wait_for(0, 300);
        chk_reqs(none, 1'b0);
        $display("warm response test done");
    endtask
    task automatic t_wd_update();
        fire_wd(reset_seq_pkg::WD_COLD_UPDATE, 4'h4);
        wait_for(0, 300);
        chk_reqs('{4'h9, 4'h8}, 1'b1);
        chk({7'h0, cur_factory}, 8'h01, "factory");
        $display("update response test done");
    endtask
    task automatic t_ldr_fail();
        fail_mask <= 16'h0100;
        fire_wd(reset_seq_pkg::WD_COLD, 4'h8);
        wait_for(2, 300);
        chk_reqs('{4'h8}, 1'b0);
        repeat (8) @(posedge clk);
        chk({7'h0, proc_reset}, 8'h01, "held");
        $display("loader failure test done");
    endtask
    task automatic t_reconfig();
        fail_mask <= 16'h0022;
        @(posedge clk);
        reconfig_request_n <= 1'b0;
        repeat (4) @(posedge clk);
        reconfig_request_n <= 1'b1;
        wait_for(0, 300);
        chk_reqs('{4'h5, 4'h1, 4'h9, 4'h8}, 1'b1);
        chk({7'h0, load_failed}, 8'h00, "failed cleared");
        $display("reconfig fallback test done");
    endtask
    task automatic t_cold_pin();
        @(posedge clk);
        ext_n <= 1'b0;
        wait_for(1, 10);
        chk({7'h0, proc_reset}, 8'h01, "pin reset");
        repeat (4) @(posedge clk);
        ext_n <= 1'b1;
        wait_for(0, 300);
        chk_reqs('{4'h8}, 1'b0);
        $display("cold pin test done");
    endtask
    task automatic t_factory_pin();
        fail_mask <= 16'h0000;
        @(posedge clk);
        reconfig_request_n <= 1'b0;
        wait_for(1, 10);
        chk({7'h0, proc_reset}, 8'h01, "reconfig reset");
        power_up(1'b1);
        wait_for(0, 300);
        chk_reqs('{4'hD, 4'hC}, 1'b1);
        $display("factory pin test done");
    endtask
    initial begin
        t_boot();
        t_wd_cold();
        t_wd_warm();
        t_wd_update();
        t_ldr_fail();
        t_reconfig();
        t_cold_pin();
        t_factory_pin();
        wrap_up();
    end
endmodule
